// *** verilog/tios_cfg.svh ***
// Offsets, field positions, reset values and timing for the status words
`ifndef TIOS_CFG_SVH
`define TIOS_CFG_SVH

`define TIOS_PAGE 4'h4
`define TIOS_OFS_OVF_IRQ 5'h1d
`define TIOS_OFS_EVT_IRQ 5'h1e
`define TIOS_OFS_OVF_LATCH 5'h1f
`define TIOS_RST_WORD 8'h00
`define TIOS_UNMAPPED 8'h00

`define TIOS_EVT_LINK_A 7
`define TIOS_EVT_LINK_B 6
`define TIOS_EVT_LINK_C 5
`define TIOS_EVT_LOOP 4
`define TIOS_EVT_ONE_SEC 3
`define TIOS_EVT_FIVE_SEC 2
`define TIOS_EVT_BIT_MSG 1
`define TIOS_EVT_SIG 0

`define TIOS_LOOP_HOLD_MS 48
`define TIOS_CLK_PERIOD_PS 5000
`define TIOS_LOOP_HOLD_CYC \
    ((64'd`TIOS_LOOP_HOLD_MS * 64'd1000000000) / 64'd`TIOS_CLK_PERIOD_PS)

`define TIOS_MSG_BITS 17
`define TIOS_MSG_MATCH 17'h1fe00
`define TIOS_MSG_CARE 17'h1ff01
`define TIOS_MSG_HIST 10
`define TIOS_MSG_NEED 4'h8

`endif

// *** verilog/tios_pkg.sv ***
// Types shared by the status word logic
package tios_pkg;
    typedef enum logic [1:0] {
        TIOS_LOOP_IDLE = 2'b00,
        TIOS_LOOP_TIMING = 2'b01,
        TIOS_LOOP_REPORTED = 2'b11
    } tios_loop_state_type;
    typedef logic [6:0] tios_msg_type;
    typedef logic [7:0] tios_word_type;
endpackage

// *** verilog/tios_status.sv ***
// Counter overflow, event interrupt and overflow latch status words
`timescale 1ns/10ps
`include "tios_cfg.svh"
module tios_status
#(
    parameter logic [23:0] LOOP_HOLD_CYCLES = 24'(`TIOS_LOOP_HOLD_CYC)
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port, page 4 words
    input wire logic regRead,
    input wire logic [3:0] regPage,
    input wire logic [4:0] regAddr,
    output tios_pkg::tios_word_type regRdData,
    // Masks, 1 = unmasked
    input wire logic [7:0] ovfMask,
    input wire logic [7:0] evtMask,
    // Counter wrap pulses, bit order as the words
    input wire logic [7:0] ctrWrap,
    // Event sources
    input wire logic [2:0] linkCtrlIrq,
    input wire logic loopUpPresent,
    input wire logic loopDownPresent,
    input wire logic one_second_flag,
    input wire logic fiveSecondFlag,
    input wire logic facility_data_link,
    input wire logic fdlBitValid,
    input wire logic [3:0] sigBits,
    input wire logic sigFourBit,
    input wire logic sigUpdate,
    input wire logic signalling_debounce_enable,
    // Interrupt request
    output logic irqReqN
);
    import tios_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    tios_word_type ovfIrq_q;
    tios_word_type ovfIrq_d;
    tios_word_type evtIrq_q;
    tios_word_type evtIrq_d;
    tios_word_type ovfLatch_q;
    tios_word_type ovfLatch_d;
    tios_word_type evtSet;
    tios_word_type rdData_q;
    logic irqReqN_q;
    logic pageHit;
    logic rdOvf;
    logic rdEvt;
    logic rdLatch;

    assign pageHit = regRead && (regPage == `TIOS_PAGE);
    assign rdOvf = pageHit && (regAddr == `TIOS_OFS_OVF_IRQ);
    assign rdEvt = pageHit && (regAddr == `TIOS_OFS_EVT_IRQ);
    assign rdLatch = pageHit && (regAddr == `TIOS_OFS_OVF_LATCH);

    // Loop code timer
    tios_loop_state_type loopState_q;
    logic [23:0] loopCnt_q;
    logic loopUpPrev_q;
    logic loopDownPrev_q;
    logic loopPresent;
    logic loopChanged;
    logic loopDone;

    assign loopPresent = loopUpPresent || loopDownPresent;
    assign loopChanged = (loopUpPresent != loopUpPrev_q)
        || (loopDownPresent != loopDownPrev_q);
    assign loopDone = (loopState_q == TIOS_LOOP_TIMING) && !loopChanged
        && loopPresent && (loopCnt_q == LOOP_HOLD_CYCLES - 24'h000001);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            loopState_q <= TIOS_LOOP_IDLE;
            loopCnt_q <= 24'h000000;
            loopUpPrev_q <= 1'b0;
            loopDownPrev_q <= 1'b0;
        end
        else
        begin
            loopUpPrev_q <= loopUpPresent;
            loopDownPrev_q <= loopDownPresent;
            case (loopState_q)
                TIOS_LOOP_IDLE:
                begin
                    loopCnt_q <= 24'h000000;
                    if (loopPresent)
                        loopState_q <= TIOS_LOOP_TIMING;
                end
                TIOS_LOOP_TIMING:
                begin
                    if (!loopPresent)
                        loopState_q <= TIOS_LOOP_IDLE;
                    else if (loopChanged)
                        loopCnt_q <= 24'h000000;
                    else if (loopDone)
                        loopState_q <= TIOS_LOOP_REPORTED;
                    else
                        loopCnt_q <= loopCnt_q + 24'h000001;
                end
                TIOS_LOOP_REPORTED:
                begin
                    loopCnt_q <= 24'h000000;
                    if (!loopPresent || loopChanged)
                        loopState_q <= TIOS_LOOP_IDLE;
                end
                default:
                begin
                    loopState_q <= TIOS_LOOP_IDLE;
                    loopCnt_q <= 24'h000000;
                end
            endcase
        end
    end

    // Second flag edge detection
    logic oneSecPrev_q;
    logic fiveSecPrev_q;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            oneSecPrev_q <= 1'b0;
            fiveSecPrev_q <= 1'b0;
        end
        else
        begin
            oneSecPrev_q <= one_second_flag;
            fiveSecPrev_q <= fiveSecondFlag;
        end
    end

    // Bit oriented message receiver on the data link
    logic [16:0] fdlShift_q;
    logic [4:0] slotCnt_q;
    tios_msg_type msgHist_q [`TIOS_MSG_HIST];
    logic [`TIOS_MSG_HIST-1:0] histValid_q;
    tios_msg_type lastMsg_q;
    logic lastValid_q;
    logic [16:0] fdlNext;
    logic msgMatch;
    logic slotEnd;
    tios_msg_type newMsg;
    logic [3:0] agreeCnt;
    logic msgAccept;

    assign fdlNext = {fdlShift_q[15:0], facility_data_link};
    assign msgMatch = fdlBitValid
        && ((fdlNext & `TIOS_MSG_CARE) == `TIOS_MSG_MATCH);
    assign slotEnd = fdlBitValid && !msgMatch
        && (slotCnt_q == 5'(`TIOS_MSG_BITS - 1));
    assign newMsg = fdlNext[7:1];

    always_comb
    begin
        agreeCnt = 4'h1;
        for (int i = 0; i < `TIOS_MSG_HIST - 1; i++)
            if (histValid_q[i] && (msgHist_q[i] == newMsg))
                agreeCnt = agreeCnt + 4'h1;
    end

    assign msgAccept = msgMatch && (agreeCnt >= `TIOS_MSG_NEED)
        && !(lastValid_q && (lastMsg_q == newMsg));

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            fdlShift_q <= 17'h00000;
            slotCnt_q <= 5'h00;
            histValid_q <= '0;
            lastMsg_q <= 7'h00;
            lastValid_q <= 1'b0;
            for (int i = 0; i < `TIOS_MSG_HIST; i++)
                msgHist_q[i] <= 7'h00;
        end
        else if (fdlBitValid)
        begin
            fdlShift_q <= fdlNext;
            if (msgMatch || slotEnd)
            begin
                slotCnt_q <= 5'h00;
                histValid_q <= {histValid_q[`TIOS_MSG_HIST-2:0], msgMatch};
                msgHist_q[0] <= newMsg;
                for (int i = 1; i < `TIOS_MSG_HIST; i++)
                    msgHist_q[i] <= msgHist_q[i-1];
            end
            else
                slotCnt_q <= slotCnt_q + 5'h01;
            if (msgAccept)
            begin
                lastMsg_q <= newMsg;
                lastValid_q <= 1'b1;
            end
        end
    end

    // Signalling change detection with optional debounce
    logic [3:0] sigStable_q;
    logic [3:0] sigCand_q;
    logic [3:0] sigSample;
    logic sigChange;

    assign sigSample = sigFourBit ? sigBits : {sigBits[3:2], 2'b00};
    assign sigChange = sigUpdate && (sigSample != sigStable_q)
        && (!signalling_debounce_enable || (sigSample == sigCand_q));

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sigStable_q <= 4'h0;
            sigCand_q <= 4'h0;
        end
        else if (sigUpdate)
        begin
            sigCand_q <= sigSample;
            if (sigChange)
                sigStable_q <= sigSample;
        end
    end

    // Event word set terms, gated by mask except the link controller bits 7 to 5
    always_comb
    begin
        evtSet = 8'h00;
        evtSet[`TIOS_EVT_LINK_A] = linkCtrlIrq[0];
        evtSet[`TIOS_EVT_LINK_B] = linkCtrlIrq[1];
        evtSet[`TIOS_EVT_LINK_C] = linkCtrlIrq[2];
        evtSet[`TIOS_EVT_LOOP] = loopDone && evtMask[`TIOS_EVT_LOOP];
        evtSet[`TIOS_EVT_ONE_SEC] = one_second_flag && !oneSecPrev_q
            && evtMask[`TIOS_EVT_ONE_SEC];
        evtSet[`TIOS_EVT_FIVE_SEC] = fiveSecondFlag && !fiveSecPrev_q
            && evtMask[`TIOS_EVT_FIVE_SEC];
        evtSet[`TIOS_EVT_BIT_MSG] = msgAccept
            && evtMask[`TIOS_EVT_BIT_MSG];
        evtSet[`TIOS_EVT_SIG] = sigChange && evtMask[`TIOS_EVT_SIG];
    end

    // Read clear; a set in the read cycle survives
    assign ovfIrq_d = (rdOvf ? 8'h00 : ovfIrq_q)
        | (ctrWrap & ovfMask);
    assign evtIrq_d = (rdEvt ? 8'h00 : evtIrq_q) | evtSet;
    assign ovfLatch_d = (rdLatch ? 8'h00 : ovfLatch_q) | ctrWrap;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ovfIrq_q <= `TIOS_RST_WORD;
            evtIrq_q <= `TIOS_RST_WORD;
            ovfLatch_q <= `TIOS_RST_WORD;
        end
        else
        begin
            ovfIrq_q <= ovfIrq_d;
            evtIrq_q <= evtIrq_d;
            ovfLatch_q <= ovfLatch_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rdData_q <= `TIOS_RST_WORD;
        else if (regRead)
        begin
            if (rdOvf)
                rdData_q <= ovfIrq_q;
            else if (rdEvt)
                rdData_q <= evtIrq_q;
            else if (rdLatch)
                rdData_q <= ovfLatch_q;
            else
                rdData_q <= `TIOS_UNMAPPED;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            irqReqN_q <= 1'b1;
        else
            irqReqN_q <= !((|ovfIrq_d) || (|evtIrq_d));
    end

    assign regRdData = rdData_q;
    assign irqReqN = irqReqN_q;

    AST_FE_OVF_SET: assert property (ctrWrap[7] && ovfMask[7]
        |=> ovfIrq_q[7] ##1 (ovfIrq_q[7] || $past(rdOvf)))
        else $error("framing overflow bit not set");
    AST_CRC_OVF_SET: assert property (ctrWrap[6] && ovfMask[6]
        |=> ovfIrq_q[6] && !irqReqN)
        else $error("crc overflow bit not set");
    AST_OVF_CAUSE: assert property (
        (ovfIrq_q & ~$past(ovfIrq_q) & ~($past(ctrWrap) & $past(ovfMask)))
        == 8'h00)
        else $error("overflow bit set without unmasked wrap");
    AST_OVF_READ_CLR: assert property (rdOvf && ctrWrap == 8'h00
        |=> ovfIrq_q == 8'h00 && regRdData == $past(ovfIrq_q))
        else $error("overflow word read did not clear");
    AST_LINK_SET: assert property (linkCtrlIrq != 3'b000
        |=> evtIrq_q[7:5] == ({$past(linkCtrlIrq[0]), $past(linkCtrlIrq[1]),
        $past(linkCtrlIrq[2])}
        | ($past(rdEvt) ? 3'b000 : $past(evtIrq_q[7:5]))))
        else $error("link controller bit wrong");
    AST_LOOP_SET: assert property ($rose(evtIrq_q[4])
        |-> $past(loopState_q) == TIOS_LOOP_TIMING && $past(evtMask[4])
        && $past(loopCnt_q) == LOOP_HOLD_CYCLES - 24'h000001)
        else $error("loop code bit set before hold time");
    AST_ONE_SEC_SET: assert property ($rose(one_second_flag)
        && evtMask[3] |=> evtIrq_q[3])
        else $error("one second bit not set");
    AST_FIVE_SEC_SET: assert property ($rose(evtIrq_q[2])
        |-> $past(fiveSecondFlag) && !$past(fiveSecPrev_q)
        && $past(evtMask[2]))
        else $error("five second bit set without edge");
    AST_BIT_MSG_SET: assert property ($rose(evtIrq_q[1])
        |-> $past(msgMatch) && $past(agreeCnt) >= 4'h8 && $past(evtMask[1]))
        else $error("message bit set without agreement");
    AST_SIG_SET: assert property (sigUpdate && sigSample != sigStable_q
        && evtMask[0] && !signalling_debounce_enable |=> evtIrq_q[0])
        else $error("signalling change missed");
    AST_LATCH_SET: assert property (ctrWrap != 8'h00
        |=> (ovfLatch_q & $past(ctrWrap)) == $past(ctrWrap))
        else $error("overflow latch not set");
    AST_IRQ_LEVEL: assert property (
        irqReqN == !((|ovfIrq_q) || (|evtIrq_q)))
        else $error("interrupt request disagrees with words");

endmodule // tios_status

// *** verif/tb.sv ***
// Self-checking bench for the status word block
`timescale 1ns/10ps
`include "tios_cfg.svh"
module tb;
    import tios_pkg::*;
    localparam logic [23:0] HOLD = 24'd20;
    logic clk_sys, rstn, regRead, one_second_flag, fiveSecondFlag;
    logic loopUpPresent, loopDownPresent, facility_data_link, fdlBitValid;
    logic sigFourBit, sigUpdate, signalling_debounce_enable;
    logic [3:0] regPage, sigBits;
    logic [4:0] regAddr;
    logic [7:0] ovfMask, evtMask, ctrWrap, wrapV, expV;
    logic [2:0] linkCtrlIrq;
    tios_word_type regRdData;
    logic irqReqN;
    logic [31:0] seed;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    tios_status #(.LOOP_HOLD_CYCLES(HOLD)) u_dut
    (
        .clk_sys(clk_sys), .rstn(rstn), .regRead(regRead),
        .regPage(regPage), .regAddr(regAddr), .regRdData(regRdData),
        .ovfMask(ovfMask), .evtMask(evtMask), .ctrWrap(ctrWrap),
        .linkCtrlIrq(linkCtrlIrq), .loopUpPresent(loopUpPresent),
        .loopDownPresent(loopDownPresent),
        .one_second_flag(one_second_flag), .fiveSecondFlag(fiveSecondFlag),
        .facility_data_link(facility_data_link), .fdlBitValid(fdlBitValid),
        .sigBits(sigBits), .sigFourBit(sigFourBit), .sigUpdate(sigUpdate),
        .signalling_debounce_enable(signalling_debounce_enable),
        .irqReqN(irqReqN)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Received order: eight ones, zero, seven message bits, zero
    function automatic logic [16:0] msgBits(input tios_msg_type mv);
        return {8'hff, 1'b0, mv, 1'b0};
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk8(input string name, input tios_word_type e,
                        input tios_word_type g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk1(input string name, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // One read strobe; data is settled by the following falling edge
    task automatic rdChk(input logic [3:0] pg, input logic [4:0] a,
                         input tios_word_type e);
        regRead = 1'b1;
        regPage = pg;
        regAddr = a;
        cyc(1);
        chk8($sformatf("word %h:%h", pg, a), e, regRdData);
        regRead = 1'b0;
        cyc(1);
    endtask

    task automatic sigSample(input logic [3:0] v);
        sigBits = v;
        sigUpdate = 1'b1;
        cyc(1);
        sigUpdate = 1'b0;
        cyc(1);
    endtask

    task automatic sendMsg(input tios_msg_type mv, input int n);
        logic [16:0] b;
        b = msgBits(mv);
        repeat (n)
            for (int k = 16; k >= 0; k--)
            begin
                facility_data_link = b[k];
                fdlBitValid = 1'b1;
                cyc(1);
                fdlBitValid = 1'b0;
                facility_data_link = ~b[k];
                cyc(1);
            end
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    initial
    begin
        {rstn, regRead, one_second_flag, fiveSecondFlag} = 4'h0;
        {loopUpPresent, loopDownPresent, fdlBitValid, sigUpdate} = 4'h0;
        {facility_data_link, signalling_debounce_enable} = 2'b00;
        sigFourBit = 1'b1;
        regPage = 4'h0;
        regAddr = 5'h00;
        sigBits = 4'h0;
        {ovfMask, evtMask, ctrWrap} = 24'h000000;
        linkCtrlIrq = 3'h0;
        seed = 32'h32c2c37f;
        cyc(6);
        rstn = 1'b1;
        cyc(1);
        chk1("irq after reset", 1'b1, irqReqN);
        rdChk(4'h4, `TIOS_OFS_OVF_IRQ, `TIOS_RST_WORD);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, `TIOS_RST_WORD);
        rdChk(4'h4, `TIOS_OFS_OVF_LATCH, `TIOS_RST_WORD);
        // Walking single wraps, then random wraps under random masks
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            ovfMask = (i < 8) ? 8'hff : seed[7:0];
            wrapV = (i < 8) ? 8'h01 << i : seed[15:8];
            expV = wrapV & ovfMask;
            ctrWrap = wrapV;
            cyc(1);
            ctrWrap = 8'h00;
            cyc(1);
            chk1("irq ovf", ~|expV, irqReqN);
            if (i == 3)
            begin
                rdChk(4'h3, `TIOS_OFS_OVF_IRQ, `TIOS_UNMAPPED);
                rdChk(4'h4, 5'h1c, `TIOS_UNMAPPED);
            end
            rdChk(4'h4, `TIOS_OFS_OVF_IRQ, expV);
            rdChk(4'h4, `TIOS_OFS_OVF_LATCH, wrapV);
            rdChk(4'h4, `TIOS_OFS_OVF_IRQ, 8'h00);
            rdChk(4'h4, `TIOS_OFS_OVF_LATCH, 8'h00);
            chk1("irq cleared", 1'b1, irqReqN);
        end
        // Link controllers, back to back
        evtMask = 8'hff;
        linkCtrlIrq = 3'b101;
        cyc(1);
        linkCtrlIrq = 3'b010;
        cyc(1);
        linkCtrlIrq = 3'b000;
        cyc(1);
        chk1("irq evt", 1'b0, irqReqN);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'he0);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h00);
        chk1("irq evt cleared", 1'b1, irqReqN);
        // Status flag rising edges, masked then unmasked
        evtMask = 8'h00;
        {one_second_flag, fiveSecondFlag} = 2'b11;
        cyc(3);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h00);
        {one_second_flag, fiveSecondFlag} = 2'b00;
        evtMask = 8'hff;
        cyc(3);
        {one_second_flag, fiveSecondFlag} = 2'b11;
        cyc(3);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h0c);
        cyc(3);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h00);
        // Loop code: too short, then held long enough, reported once
        loopUpPresent = 1'b1;
        cyc(HOLD / 2);
        loopUpPresent = 1'b0;
        cyc(3);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h00);
        loopDownPresent = 1'b1;
        cyc(HOLD + 6);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h10);
        cyc(HOLD + 6);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h00);
        loopDownPresent = 1'b0;
        // Bit message: seven positions too few, ten enough
        sendMsg(7'h2a, 7);
        cyc(3);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h00);
        sendMsg(7'h2a, 3);
        cyc(3);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h02);
        // Signalling change, plain then debounced
        sigSample(4'h5);
        cyc(1);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h01);
        signalling_debounce_enable = 1'b1;
        sigSample(4'ha);
        sigSample(4'h5);
        cyc(1);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h00);
        sigSample(4'ha);
        sigSample(4'ha);
        cyc(1);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h01);
        // Two-bit signalling ignores the lower pair
        signalling_debounce_enable = 1'b0;
        sigFourBit = 1'b0;
        sigSample(4'hb);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h01);
        sigSample(4'h9);
        rdChk(4'h4, `TIOS_OFS_EVT_IRQ, 8'h00);
        chk1("irq final", 1'b1, irqReqN);
        give_verdict();
    end
endmodule // tb
